// [rtl/pts_pkg.sv]
package pts_pkg;

    // ========================================================
    // Register map (word index on the plain register port)
    // ========================================================
    localparam logic [2:0] ADDR_CONFIG   = 3'h0;
    localparam logic [2:0] ADDR_PRESCALE = 3'h1;
    localparam logic [2:0] ADDR_RELOAD   = 3'h2;
    localparam logic [2:0] ADDR_CTRL     = 3'h3;
    localparam logic [2:0] ADDR_COUNT    = 3'h4;
    localparam logic [2:0] ADDR_MATCH    = 3'h5;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int CFG_LOCK_CFG   = 0;
    localparam int CFG_LOCK_PRE   = 1;
    localparam int CFG_LOCK_TMR   = 2;
    localparam int CFG_LOCK_CNT   = 3;
    localparam int CFG_CLK_SEL    = 4;
    localparam int CFG_MATCH_EN   = 5;
    localparam int CTRL_RESTART   = 0;
    localparam int CTRL_TERMINAL  = 1;

    // ========================================================
    // Reset values and constants
    // ========================================================
    localparam logic [5:0]  CONFIG_RESET   = 6'h00;
    localparam logic [2:0]  PRESCALE_RESET = 3'h0;
    localparam logic [15:0] RELOAD_RESET   = 16'hffff;
    localparam logic [7:0]  COUNT_RESET    = 8'h0f;
    localparam logic [7:0]  SERVICE_KEY    = 8'h5c;
    localparam logic [2:0]  DIVIDE_MAX     = 3'h5;

    // Register port request from firmware
    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pts_bus_req_t;

endpackage

// [rtl/pts_timer_supervisor.sv]
// Function
// - Prescaler divides slow clock by two to the divide field, 1:1 to 1:32.
// - Periodic timer is a 16-bit down-counter on prescaled clock, auto reload.
// - Tick pulse is high for exactly one prescaled cycle when timer hits zero.
// - New reload value only takes effect at the next load, after zero or on restart.
// - Restart bit reloads timer on next prescaled edge, then self-clears.
// - With divide field zero a count may be skipped on load.
// - Supervisor is 8-bit down-counter on selected clock, disabled after reset.
// - An unlocked count write or a match write with match enabled starts supervisor; only reset stops it.
// - Unlocked count write stores value and restarts countdown from it.
// - With match enabled, 5Ch restarts from stored count; other data times out.
// - Supervisor reaching zero raises timeout as late service.
// - Two services within one supervisor clock raise timeout as early service.
// - Clock select 0 picks tick, 1 picks prescaled; hardware select overrides.
// - Changing supervisor clock may gain or lose one cycle.
// - Config, prescale, count locks block writes, reads undefined; reset clears.
// - Timer lock blocks reload and control writes and reload reads.
// - Match register writes ignored while match service disabled.
// - Reset clears config and prescale registers.
// - Counters keep running in idle; registers accessed only when active.
// - Prescale, reload, count writes may take up to 3 slow cycles.
// - Terminal-count flag set at zero, cleared by any control read.
// - Count register resets to 0Fh and is loaded on each service.
module pts_timer_supervisor
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // Register port
    input  wire pts_pkg::pts_bus_req_t bus_req,
    output logic [15:0]                rd_data,
    // Pins from outside the core clock domain
    input  wire logic                  slow_clk,
    input  wire logic                  alt_clk_sel,
    input  wire logic                  alt_clk,
    // Outputs to interrupt and reset logic
    output logic                       periodic_tick_pulse,
    output logic                       supervisor_timeout
);

    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        logic [2:0]  slow_sync;
        logic [1:0]  sel_sync;
        logic [2:0]  alt_sync;
        logic [5:0]  config_r;
        logic [2:0]  divide;
        logic [15:0] reload;
        logic        restart;
        logic        terminal;
        logic [7:0]  count_r;
        logic [4:0]  presc;
        logic [15:0] timer;
        logic        tick;
        logic        wd_run;
        logic [7:0]  wd_cnt;
        logic        wd_served;
        logic        timeout;
        logic [15:0] rdata;
    } pts_state_t;

    pts_state_t st;
    pts_state_t next_st;

    // Mask of prescaler bits that must be all ones for a prescaled edge
    function automatic logic [4:0] div_mask(input logic [2:0] code);
        logic [2:0] c;
        c = (code > pts_pkg::DIVIDE_MAX) ? pts_pkg::DIVIDE_MAX : code;
        return 5'((6'h01 << c) - 6'h01);
    endfunction

    // ========================================================
    // Next-state logic
    // ========================================================
    always_comb
    begin
        logic slow_edge;
        logic alt_edge;
        logic presc_tick;
        logic wd_clk;
        logic service;
        logic fault;
        logic lock_cfg;
        logic lock_pre;
        logic lock_tmr;
        logic lock_cnt;
        logic match_en;
        slow_edge  = 1'b0;
        alt_edge   = 1'b0;
        presc_tick = 1'b0;
        wd_clk     = 1'b0;
        service    = 1'b0;
        fault      = 1'b0;
        lock_cfg   = st.config_r[pts_pkg::CFG_LOCK_CFG];
        lock_pre   = st.config_r[pts_pkg::CFG_LOCK_PRE];
        lock_tmr   = st.config_r[pts_pkg::CFG_LOCK_TMR];
        lock_cnt   = st.config_r[pts_pkg::CFG_LOCK_CNT];
        match_en   = st.config_r[pts_pkg::CFG_MATCH_EN];
        next_st    = st;

        // Two-flop synchronisers, third stage only for edge detection
        next_st.slow_sync = {st.slow_sync[1:0], slow_clk};
        next_st.sel_sync  = {st.sel_sync[0], alt_clk_sel};
        next_st.alt_sync  = {st.alt_sync[1:0], alt_clk};
        slow_edge = st.slow_sync[1] & ~st.slow_sync[2];
        alt_edge  = st.alt_sync[1] & ~st.alt_sync[2];

        // Prescaler: a prescaled edge every 2^divide slow edges, divide codes above 5 taken as 5
        // No power-mode gating: both counters run on in idle
        if (slow_edge)
        begin
            next_st.presc = st.presc + 5'h01;
            presc_tick = (st.presc & div_mask(st.divide))
                         == div_mask(st.divide);
        end

        // Periodic timer; it runs whatever the power mode
        if (presc_tick)
        begin
            // Load happens on a prescaled edge, never a skipped count here
            if (st.restart || st.timer == 16'h0000)
            begin
                next_st.timer   = st.reload;
                next_st.restart = 1'b0;
            end
            else
            begin
                next_st.timer = st.timer - 16'h0001;
            end
            // Tick holds for the whole prescaled cycle spent at zero
            next_st.tick = (next_st.timer == 16'h0000);
            if (next_st.timer == 16'h0000)
            begin
                next_st.terminal = 1'b1;
            end
        end

        // Supervisor clock source; the pin select wins
        // A source switch mid-cycle may add or drop one clock
        if (st.sel_sync[1])
        begin
            wd_clk = alt_edge;
        end
        else if (st.config_r[pts_pkg::CFG_CLK_SEL])
        begin
            wd_clk = presc_tick;
        end
        else
        begin
            wd_clk = next_st.tick & ~st.tick;
        end

        // Supervisor countdown, idle until first service
        if (st.wd_run && wd_clk)
        begin
            next_st.wd_served = 1'b0;
            if (st.wd_cnt <= 8'h01)
            begin
                fault = 1'b1;
                next_st.wd_cnt = st.count_r;
            end
            else
            begin
                next_st.wd_cnt = st.wd_cnt - 8'h01;
            end
        end

        // Register writes land at once, inside the allowed delay
        if (bus_req.wr)
        begin
            unique case (bus_req.addr)
                pts_pkg::ADDR_CONFIG:
                    if (!lock_cfg)
                    begin
                        // Lock bits are sticky until reset
                        next_st.config_r = bus_req.wdata[5:0]
                                         | {2'b00, st.config_r[3:0]};
                    end
                pts_pkg::ADDR_PRESCALE:
                    if (!lock_pre)
                    begin
                        next_st.divide = bus_req.wdata[2:0];
                    end
                pts_pkg::ADDR_RELOAD:
                    if (!lock_tmr)
                    begin
                        next_st.reload = bus_req.wdata;
                    end
                pts_pkg::ADDR_CTRL:
                    if (!lock_tmr && bus_req.wdata[pts_pkg::CTRL_RESTART])
                    begin
                        next_st.restart = 1'b1;
                    end
                pts_pkg::ADDR_COUNT:
                    if (!lock_cnt)
                    begin
                        next_st.count_r = bus_req.wdata[7:0];
                        next_st.wd_cnt  = bus_req.wdata[7:0];
                        service = 1'b1;
                    end
                pts_pkg::ADDR_MATCH:
                    if (match_en)
                    begin
                        service = 1'b1;
                        next_st.wd_cnt = st.count_r;
                        if (bus_req.wdata[7:0] != pts_pkg::SERVICE_KEY)
                        begin
                            fault = 1'b1;
                        end
                    end
                default:
                begin
                end
            endcase
        end

        // A service in the clock's own cycle counts as this cycle's
        if (service)
        begin
            if (st.wd_run && st.wd_served)
            begin
                fault = 1'b1;
            end
            next_st.wd_run    = 1'b1;
            next_st.wd_served = 1'b1;
        end

        next_st.timeout = fault;

        // Register reads; locked registers read as zero
        next_st.rdata = 16'h0000;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                pts_pkg::ADDR_CONFIG:
                    next_st.rdata = lock_cfg ? 16'h0000
                                  : {10'h000, st.config_r};
                pts_pkg::ADDR_PRESCALE:
                    next_st.rdata = lock_pre ? 16'h0000
                                  : {13'h0000, st.divide};
                pts_pkg::ADDR_RELOAD:
                    next_st.rdata = lock_tmr ? 16'h0000 : st.reload;
                pts_pkg::ADDR_CTRL:
                begin
                    next_st.rdata = {14'h0000, st.terminal, st.restart};
                    // A new terminal count in the same cycle survives
                    next_st.terminal = presc_tick
                                     && next_st.timer == 16'h0000;
                end
                default:
                    next_st.rdata = 16'h0000;
            endcase
        end
    end

    // ========================================================
    // State register
    // ========================================================
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st           <= '0;
            st.config_r  <= pts_pkg::CONFIG_RESET;
            st.divide    <= pts_pkg::PRESCALE_RESET;
            st.reload    <= pts_pkg::RELOAD_RESET;
            st.count_r   <= pts_pkg::COUNT_RESET;
            st.timer     <= pts_pkg::RELOAD_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data             = st.rdata;
    assign periodic_tick_pulse = st.tick;
    assign supervisor_timeout  = st.timeout;

endmodule

// [test/pts_props.sv]
module pts_props
(
    // Watched ports
    input wire logic                  core_clk,
    input wire logic                  rstn,
    input wire pts_pkg::pts_bus_req_t bus_req,
    input wire logic [15:0]           rd_data,
    input wire logic                  slow_clk,
    input wire logic                  alt_clk_sel,
    input wire logic                  alt_clk,
    input wire logic                  periodic_tick_pulse,
    input wire logic                  supervisor_timeout
);
    // ====================================
    // Shadow state
    // ====================================
    logic [5:0] cfg;
    logic       started;
    logic       last_slow;
    logic [3:0] quiet;
    wire logic  wcnt = bus_req.wr && bus_req.addr == pts_pkg::ADDR_COUNT;
    wire logic  wmat = bus_req.wr && bus_req.addr == pts_pkg::ADDR_MATCH;
    wire logic  rcfg = bus_req.rd && bus_req.addr == pts_pkg::ADDR_CONFIG;

    // Lock bits only ever set; quiet guards against a sync edge in flight
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg <= 6'h00;
            started <= 1'b0;
            last_slow <= 1'b0;
            quiet <= 4'h0;
        end
        else
        begin
            if (bus_req.wr && bus_req.addr == pts_pkg::ADDR_CONFIG && !cfg[0])
                cfg <= {bus_req.wdata[5:4], bus_req.wdata[3:0] | cfg[3:0]};
            started <= started | wcnt | wmat;
            last_slow <= slow_clk;
            quiet <= (slow_clk != last_slow) ? 4'h0
                   : (quiet == 4'hf) ? quiet : quiet + 4'h1;
        end
    end

    // ====================================
    // Properties
    // ====================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_early_service: assert property (wcnt && !cfg[3] && quiet > 4'h8
        && !alt_clk_sel ##1 wcnt |=> supervisor_timeout)
        else $error("second service in one clock kept quiet");
    a_bad_match: assert property (wmat && cfg[5]
        && bus_req.wdata[7:0] != pts_pkg::SERVICE_KEY |=> supervisor_timeout)
        else $error("wrong match data kept quiet");
    a_timeout_pulse: assert property (supervisor_timeout && !bus_req.wr
        |=> !supervisor_timeout)
        else $error("timeout longer than one cycle");
    a_stopped_quiet: assert property (!started |-> !supervisor_timeout)
        else $error("timeout before supervisor start");
    a_tick_stands: assert property ($rose(periodic_tick_pulse)
        |=> periodic_tick_pulse [*8])
        else $error("tick shorter than a prescaled cycle");
    a_rd_idle: assert property (!$past(bus_req.rd)
        |-> rd_data == 16'h0000)
        else $error("read data outside answer cycle");
    a_cfg_read: assert property (rcfg && !cfg[0]
        |=> rd_data == {10'h000, $past(cfg)})
        else $error("config read mismatch");
    a_locked_read: assert property (bus_req.rd && (
        (bus_req.addr == pts_pkg::ADDR_PRESCALE && cfg[1]) ||
        (bus_req.addr == pts_pkg::ADDR_RELOAD && cfg[2]) ||
        (bus_req.addr == pts_pkg::ADDR_CONFIG && cfg[0])) |=> rd_data == 0)
        else $error("locked register readable");
    a_wo_read: assert property (bus_req.rd
        && bus_req.addr >= pts_pkg::ADDR_COUNT |=> rd_data == 16'h0000)
        else $error("write-only or unmapped read not zero");
endmodule

// [test/pts_slow_src.sv]
module pts_slow_src
(
    // Free-running oscillator pins
    output logic slow_clk,
    output logic alt_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    // Crystal runs free; alt clock unrelated in phase
    initial
    begin
        slow_clk = 1'b0;
        forever #15259 slow_clk = ~slow_clk;
    end
    initial
    begin
        alt_clk = 1'b0;
        forever #1777 alt_clk = ~alt_clk;
    end
endmodule

// [test/pts_timer_supervisor_test.sv]
module pts_timer_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  core_clk;
    logic                  rstn;
    logic                  slow_clk;
    logic                  alt_clk;
    logic                  alt_sel;
    logic                  tick;
    logic                  tmo;
    logic [15:0]           rd_data;
    logic [15:0]           v;
    pts_pkg::pts_bus_req_t req;
    int                    n_fail;
    int                    check_count;
    int                    n_to;
    int                    n_tick;
    int                    cyc;
    int                    b;
    logic [15:0] rst_exp [8] = '{0, 0, 16'hffff, 0, 0, 0, 0, 0};

    pts_slow_src src (.slow_clk(slow_clk), .alt_clk(alt_clk));
    pts_timer_supervisor uut (.core_clk(core_clk), .rstn(rstn),
        .bus_req(req), .rd_data(rd_data), .slow_clk(slow_clk),
        .alt_clk_sel(alt_sel), .alt_clk(alt_clk),
        .periodic_tick_pulse(tick), .supervisor_timeout(tmo));

    // ====================================
    // Clock, event counters, hang guard
    // ====================================
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (tmo === 1'b1)
            n_to++;
        if (cyc == 80000)
        begin
            n_fail++;
            stop_test();
        end
    end
    always @(posedge tick)
        n_tick++;

    // ====================================
    // Bus tasks and compares
    // ====================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // Holding the strobe two edges makes two back-to-back writes
    task automatic wr(input logic [2:0] a, input logic [15:0] d, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            req <= '{a, d, 1'b1, 1'b0};
        end
        @(posedge core_clk);
        req <= '0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge core_clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge core_clk);
        req <= '0;
        #1 d = rd_data;
    endtask
    task automatic slow(input int n);
        repeat (n) @(posedge slow_clk);
        // Let the last edge clear the pin synchroniser
        repeat (4) @(posedge core_clk);
    endtask
    task automatic stop_test();
        $display("fails %0d checks %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ====================================
    // Main sequence
    // ====================================
    initial
    begin
        req = '0;
        alt_sel = 1'b0;
        rstn = 1'b0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd(i[2:0], v);
            chk(v, rst_exp[i]);
        end
        slow(4);
        chk_in(n_to, 0, 0);
        wr(pts_pkg::ADDR_CONFIG, 16'h0030, 1);
        rd(pts_pkg::ADDR_CONFIG, v);
        chk(v, 16'h0030);
        // Key write starts from the reset count
        wr(pts_pkg::ADDR_MATCH, {8'h00, pts_pkg::SERVICE_KEY}, 1);
        slow(12);
        chk_in(n_to, 0, 0);
        slow(6);
        chk_in(n_to, 1, 1);
        b = n_to;
        wr(pts_pkg::ADDR_MATCH, 16'h0033, 1);
        repeat (3) @(posedge core_clk);
        chk_in(n_to - b, 1, 1);
        // A supervisor clock must pass, or the next write is early
        slow(1);
        b = n_to;
        wr(pts_pkg::ADDR_COUNT, 16'h0003, 1);
        slow(2);
        chk_in(n_to - b, 0, 0);
        slow(2);
        chk_in(n_to - b, 1, 1);
        // Keep clear of slow edges so the checker sees a quiet window
        repeat (10) @(posedge core_clk);
        b = n_to;
        wr(pts_pkg::ADDR_COUNT, 16'h0040, 2);
        repeat (3) @(posedge core_clk);
        chk_in(n_to - b, 1, 1);
        // Pin select hands the supervisor to the alternate clock
        alt_sel <= 1'b1;
        repeat (50) @(posedge core_clk);
        b = n_to;
        wr(pts_pkg::ADDR_COUNT, 16'h0005, 1);
        repeat (200) @(posedge core_clk);
        chk_in(n_to - b, 1, 1);
        alt_sel <= 1'b0;
        // Tick rate for the first divide codes
        wr(pts_pkg::ADDR_RELOAD, 16'h0001, 1);
        for (int d = 0; d < 3; d++)
        begin
            wr(pts_pkg::ADDR_PRESCALE, d[15:0], 1);
            wr(pts_pkg::ADDR_CTRL, 16'h0001, 1);
            slow(4);
            n_tick = 0;
            slow(48);
            chk_in(n_tick, (24 >> d) - 1, (24 >> d) + 1);
        end
        rd(pts_pkg::ADDR_CTRL, v);
        chk({15'h0, v[1]}, 16'h0001);
        rd(pts_pkg::ADDR_CTRL, v);
        chk({15'h0, v[1]}, 16'h0000);
        // New reload must not cut the running count short
        @(negedge tick);
        n_tick = 0;
        wr(pts_pkg::ADDR_RELOAD, 16'hffff, 1);
        slow(12);
        chk_in(n_tick, 1, 1);
        wr(pts_pkg::ADDR_CONFIG, 16'h003e, 1);
        wr(pts_pkg::ADDR_PRESCALE, 16'h0003, 1);
        rd(pts_pkg::ADDR_PRESCALE, v);
        chk(v, 16'h0000);
        rd(pts_pkg::ADDR_RELOAD, v);
        chk(v, 16'h0000);
        wr(pts_pkg::ADDR_CONFIG, 16'h0000, 1);
        rd(pts_pkg::ADDR_CONFIG, v);
        chk(v, 16'h000e);
        b = n_to;
        wr(pts_pkg::ADDR_COUNT, 16'h0040, 2);
        repeat (3) @(posedge core_clk);
        chk_in(n_to - b, 0, 0);
        wr(pts_pkg::ADDR_CONFIG, 16'h0001, 1);
        rd(pts_pkg::ADDR_CONFIG, v);
        chk(v, 16'h0000);
        stop_test();
    end
endmodule

bind pts_timer_supervisor pts_props u_props (.core_clk(core_clk),
    .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
    .slow_clk(slow_clk), .alt_clk_sel(alt_clk_sel), .alt_clk(alt_clk),
    .periodic_tick_pulse(periodic_tick_pulse),
    .supervisor_timeout(supervisor_timeout));
